// ===== bench/test_tpio_top.sv
/*
  Self-checking bench for the three-port pin block.
  Assumes the board model and the bound checker are compiled alongside.
*/
`timescale 1ns/10ps
`define CHK(g, e) begin \
   comparisons++; \
   if ((g) !== (e)) begin \
      n_errors++; \
      $display("wrong value at %0t: %h, expected %h", $time, g, e); \
   end \
end
module test_tpio_top
   import tpio_pkg::*;
;
   int n_errors = 0;
   int comparisons = 0;
   logic clk, rst_b, wr, rd, irq, t4, t5;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata, got;
   logic [FOUR_W-1:0] chip_select_in, four_i, four_o, four_oe;
   logic [SEVEN_W-1:0] seven_i, seven_o, seven_oe, fast_ext_irq;
   logic [INP_W-1:0] inp;
   logic [10:0] ext_en, ext_val;

   tpio_top dut (.clk(clk), .rst_b(rst_b), .addr(addr), .wdata(wdata),
      .wr(wr), .rd(rd), .rdata(rdata), .irq(irq),
      .chip_select_in(chip_select_in), .four_bit_port_i(four_i),
      .four_bit_port_o(four_o), .four_bit_port_oe(four_oe),
      .seven_bit_port_i(seven_i), .seven_bit_port_o(seven_o),
      .seven_bit_port_oe(seven_oe), .input_only_port_i(inp),
      .fast_ext_irq(fast_ext_irq), .timer_four_updown_in(t4),
      .timer_five_updown_in(t5));
   tpio_board board (.four_o(four_o), .four_oe(four_oe), .four_i(four_i),
      .seven_o(seven_o), .seven_oe(seven_oe), .seven_i(seven_i),
      .ext_en(ext_en), .ext_val(ext_val));

   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // register port cycles and a settle wait for pin outputs
   task automatic wr_reg(input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [ADDR_W-1:0] a);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      got = rdata;
   endtask
   task automatic settle();
      repeat (2) @(posedge clk);
      #1;
   endtask

   task automatic wrap_up();
      $display("errors %0d, comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // reset state and an unmapped read
   task automatic t_reset();
      `CHK({four_oe, seven_oe}, 11'h000)
      rd_reg(OFF_SEVEN_DIR);
      `CHK(got, DATA_RST)
      rd_reg(8'h30);
      `CHK(got, 16'h0000)
   endtask

   // input-only pins steer the timer controls one cycle later
   task automatic t_timer();
      for (int k = 1; k < 3; k++) begin
         @(posedge clk);
         inp <= k[1:0];
         @(posedge clk);
         #1;
         `CHK({t5, t4}, k[1:0])
      end
      rd_reg(OFF_INP_PIN);
      `CHK(got, 16'h8000)
   endtask

   // falling pins set sticky status; mask gates the line
   task automatic t_irq();
      `CHK(fast_ext_irq, 7'h7F)
      wr_reg(OFF_IRQ_MSK, 16'h0001);
      @(posedge clk);
      ext_en <= 11'h030;
      settle();
      `CHK({irq, fast_ext_irq}, 8'hFC)
      rd_reg(OFF_IRQ_STS);
      `CHK(got, 16'h0003)
      wr_reg(OFF_IRQ_STS, 16'h0001);
      settle();
      `CHK(irq, 1'b0)
      wr_reg(OFF_IRQ_MSK, 16'h0002);
      settle();
      `CHK(irq, 1'b1)
      wr_reg(OFF_IRQ_MSK, 16'h0000);
      ext_en <= 11'h000;
      settle();
      `CHK(irq, 1'b0)
   endtask

   // four-bit port: push-pull, open-drain, input, chip selects
   task automatic t_four();
      wr_reg(OFF_FOUR_DAT, 16'h000A);
      wr_reg(OFF_FOUR_DIR, 16'h000F);
      settle();
      `CHK({four_oe, four_o}, 8'hFA)
      wr_reg(OFF_FOUR_OD, 16'h000F);
      wr_reg(OFF_FOUR_DIR, 16'h0003);
      settle();
      `CHK({four_oe, four_o}, 8'h10)
      rd_reg(OFF_FOUR_PIN);
      `CHK(got, 16'h000E)
      wr_reg(OFF_FOUR_OD, 16'h0000);
      wr_reg(OFF_FOUR_DIR, 16'h000F);
      wr_reg(OFF_FOUR_ALT, 16'h000F);
      for (int k = 5; k < 16; k += 5) begin
         @(posedge clk);
         chip_select_in <= k[3:0];
         settle();
         `CHK(four_o, k[3:0])
      end
   endtask

   // seven-bit port: push-pull, open-drain, back to input
   task automatic t_seven();
      wr_reg(OFF_SEVEN_DAT, 16'h5400);
      wr_reg(OFF_SEVEN_DIR, 16'hFE00);
      settle();
      `CHK({seven_oe, seven_o, fast_ext_irq}, 21'h1FD500)
      wr_reg(OFF_SEVEN_OD, 16'hFE00);
      settle();
      `CHK({seven_oe, seven_o}, 14'h2A80)
      rd_reg(OFF_SEVEN_PIN);
      `CHK(got, 16'h5400)
      wr_reg(OFF_SEVEN_DIR, 16'h0000);
      settle();
      `CHK(seven_oe, 7'h00)
   endtask

   // watchdog against a hang
   initial begin
      #20000;
      n_errors++;
      wrap_up();
   end

   // main sequence
   initial begin
      rst_b = 1'b0;
      {wr, rd, addr, wdata, chip_select_in, inp} = '0;
      {ext_en, ext_val} = '0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      #1;
      t_reset();
      t_timer();
      t_irq();
      t_four();
      t_seven();
      wrap_up();
   end
endmodule

// ===== bench/tpio_assertions.sv
/*
  Checker for the three-port pin block, bound to the top module.
  Assumes one clock domain and a synchronous active-low reset.
*/
`timescale 1ns/10ps
module tpio_assertions
   import tpio_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic rst_b, // synchronous reset, active low
   input wire logic [ADDR_W-1:0] addr, // register byte address
   input wire logic [DATA_W-1:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic irq, // level interrupt
   input wire logic [SEVEN_W-1:0] seven_bit_port_i, // seven-bit pin levels
   input wire logic [SEVEN_W-1:0] seven_bit_port_oe, // seven-bit enables
   input wire logic [FOUR_W-1:0] four_bit_port_oe, // four-bit enables
   input wire logic [INP_W-1:0] input_only_port_i, // input-only pins
   input wire logic [SEVEN_W-1:0] fast_ext_irq, // fast interrupt lines
   input wire logic timer_four_updown_in, // timer four control
   input wire logic timer_five_updown_in // timer five control
);
   // one domain: shared clock for every property, reset disable for all but p_reset_quiet
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_b);

   // steps that may raise the interrupt line
   sequence s_fast_fall;
      ($past(fast_ext_irq) & ~fast_ext_irq) != 7'h00;
   endsequence
   sequence s_bus_wr;
      $past(wr);
   endsequence

   property p_irq_rise;
      $rose(irq) |-> s_fast_fall or s_bus_wr;
   endproperty
   a_irq_rise: assert property (p_irq_rise)
      else $error("irq rose with no pin fall or write");
   property p_irq_fall;
      $fell(irq) |-> $past(wr);
   endproperty
   a_irq_fall: assert property (p_irq_fall)
      else $error("irq fell with no write");
   property p_mask_off;
      wr && addr == OFF_IRQ_MSK && wdata == 16'h0000 |=> !irq;
   endproperty
   a_mask_off: assert property (p_mask_off)
      else $error("irq stayed high with mask cleared");
   property p_fast_pin;
      (fast_ext_irq & ~$past(seven_bit_port_i)) == 7'h00;
   endproperty
   a_fast_pin: assert property (p_fast_pin)
      else $error("fast irq line high while its pin was low");
   property p_timer_four;
      $past(rst_b) |-> timer_four_updown_in == $past(input_only_port_i[0]);
   endproperty
   a_timer_four: assert property (p_timer_four)
      else $error("timer four control not following pin fourteen");
   property p_timer_five;
      $past(rst_b) |-> timer_five_updown_in == $past(input_only_port_i[1]);
   endproperty
   a_timer_five: assert property (p_timer_five)
      else $error("timer five control not following pin fifteen");
   property p_seven_oe_wr;
      seven_bit_port_oe != $past(seven_bit_port_oe)
         |-> $past(wr, 2) || !$past(rst_b);
   endproperty
   a_seven_oe_wr: assert property (p_seven_oe_wr)
      else $error("seven-bit enables moved without a write");
   property p_reset_quiet;
      disable iff (1'b0)
      !rst_b |=> four_bit_port_oe == 4'h0 && seven_bit_port_oe == 7'h00
         && fast_ext_irq == 7'h00 && !timer_four_updown_in;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet)
      else $error("outputs active during reset");
endmodule

bind tpio_top tpio_assertions u_chk (.clk(clk), .rst_b(rst_b), .addr(addr),
   .wdata(wdata), .wr(wr), .irq(irq), .seven_bit_port_i(seven_bit_port_i),
   .seven_bit_port_oe(seven_bit_port_oe), .four_bit_port_oe(four_bit_port_oe),
   .input_only_port_i(input_only_port_i), .fast_ext_irq(fast_ext_irq),
   .timer_four_updown_in(timer_four_updown_in),
   .timer_five_updown_in(timer_five_updown_in));

// ===== bench/tpio_board.sv
/*
  Board model: pull-ups on every bidirectional pin and an external
  driver per pin that the bench may enable.
  Assumes contention is never commanded by the bench.
*/
`timescale 1ns/10ps
module tpio_board (
   input wire logic [3:0] four_o, // device drive value
   input wire logic [3:0] four_oe, // device drive enable
   output logic [3:0] four_i, // four-bit pin levels
   input wire logic [6:0] seven_o, // device drive value
   input wire logic [6:0] seven_oe, // device drive enable
   output logic [6:0] seven_i, // seven-bit pin levels
   input wire logic [10:0] ext_en, // board driver enables
   input wire logic [10:0] ext_val // board driver values
);
   logic [10:0] oe;
   logic [10:0] lvl;
   // a released pin floats up, so open-drain highs read as one
   assign oe = {seven_oe, four_oe};
   assign lvl = (oe & {seven_o, four_o}) | (~oe & ext_en & ext_val)
      | (~oe & ~ext_en);
   assign four_i = lvl[3:0];
   assign seven_i = lvl[10:4];
endmodule

// ===== inc/tpio_pkg.sv
/*
  Shared constants for the three-port pin block: register offsets,
  field positions, port widths and reset values.
  Assumes a plain register port with 8-bit byte addresses, 16-bit data.
*/
// Functional notes
// - the four-bit port has one direction bit per pin.
// - a pin set as input has its output driver switched off.
// - each four-bit port output is push-pull or open-drain by its own bit.
// - the four-bit port pins carry chip selects zero to three, low bit up.
// - the seven-bit port has one direction bit per pin.
// - each seven-bit port output is push-pull or open-drain by its own bit.
// - seven-bit port pins nine to fifteen feed fast interrupts one to seven; the code holds a line low while its pin is an output.
// - the two-bit input-only port has no drivers and is only read.
// - input-only bit fourteen steers timer four, bit fifteen timer five.
package tpio_pkg;
   localparam int ADDR_W = 8;
   localparam int DATA_W = 16;
   localparam int FOUR_W = 4;
   localparam int SEVEN_W = 7;
   localparam int INP_W = 2;

   // field positions inside a 16-bit register word
   localparam int FOUR_LSB = 0;
   localparam int SEVEN_LSB = 9;
   localparam int INP_LSB = 14;
   localparam int IRQ_LSB = 0;

   // register byte offsets
   localparam logic [ADDR_W-1:0] OFF_FOUR_DAT = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_FOUR_DIR = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_FOUR_OD = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_FOUR_ALT = 8'h0C;
   localparam logic [ADDR_W-1:0] OFF_FOUR_PIN = 8'h10;
   localparam logic [ADDR_W-1:0] OFF_SEVEN_DAT = 8'h14;
   localparam logic [ADDR_W-1:0] OFF_SEVEN_DIR = 8'h18;
   localparam logic [ADDR_W-1:0] OFF_SEVEN_OD = 8'h1C;
   localparam logic [ADDR_W-1:0] OFF_SEVEN_PIN = 8'h20;
   localparam logic [ADDR_W-1:0] OFF_INP_PIN = 8'h24;
   localparam logic [ADDR_W-1:0] OFF_IRQ_STS = 8'h28;
   localparam logic [ADDR_W-1:0] OFF_IRQ_MSK = 8'h2C;

   // reset values
   localparam logic [FOUR_W-1:0] FOUR_RST = 4'h0;
   localparam logic [SEVEN_W-1:0] SEVEN_RST = 7'h00;
   localparam logic [INP_W-1:0] INP_RST = 2'h0;
   localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
   localparam logic DIR_OUT = 1'b1;
   localparam logic DIR_IN = 1'b0;
endpackage

// ===== rtl/tpio_pin_cell.sv
/*
  One output cell of a bidirectional pin: registered drive value and
  output enable, push-pull or open-drain.
  Assumes the pad combines pin_o and pin_oe outside the design.
*/
`timescale 1ns/10ps
module tpio_pin_cell
   import tpio_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic rst_b, // synchronous reset, active low
   input wire logic dir, // 1 output, 0 input
   input wire logic od, // 1 open-drain, 0 push-pull
   input wire logic val, // value to put on the pin
   output logic pin_o, // pad output level
   output logic pin_oe // pad output enable, high while driving
);
   typedef struct packed {
      logic o;
      logic oe;
   } tpio_cell_s;

   localparam tpio_cell_s CELL_RST = '{o: 1'b0, oe: 1'b0};

   tpio_cell_s st_r;
   tpio_cell_s st_nxt;

   // drive decision: input releases, open-drain only pulls low
   always_comb begin
      st_nxt.o = od ? 1'b0 : val;
      st_nxt.oe = (dir == DIR_OUT) && (!od || !val);
   end

   // cell state register, released as input at reset
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_r <= CELL_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign pin_o = st_r.o;
   assign pin_oe = st_r.oe;
endmodule

// ===== rtl/tpio_top.sv
/*
  Three small general-purpose ports: a four-bit bidirectional port with
  chip-select alternates, a seven-bit bidirectional port feeding fast
  interrupt inputs, and a two-bit input-only port feeding timer
  up/down controls. Registers on a plain strobe port; one level irq.
  Assumes pin inputs are synchronous to clk and pads resolve o/oe.
*/
`timescale 1ns/10ps
module tpio_top
   import tpio_pkg::*;
(
   input wire logic clk, // system clock, 200 MHz
   input wire logic rst_b, // synchronous reset, active low
   input wire logic [ADDR_W-1:0] addr, // register byte address
   input wire logic [DATA_W-1:0] wdata, // write data
   input wire logic wr, // write strobe
   input wire logic rd, // read strobe
   output logic [DATA_W-1:0] rdata, // read data, cycle after rd
   output logic irq, // level interrupt, unmasked status set
   input wire logic [FOUR_W-1:0] chip_select_in, // chip selects from bus ctl
   input wire logic [FOUR_W-1:0] four_bit_port_i, // four-bit port pin levels
   output logic [FOUR_W-1:0] four_bit_port_o, // four-bit port drive value
   output logic [FOUR_W-1:0] four_bit_port_oe, // four-bit port enables
   input wire logic [SEVEN_W-1:0] seven_bit_port_i, // pins nine to fifteen
   output logic [SEVEN_W-1:0] seven_bit_port_o, // seven-bit drive value
   output logic [SEVEN_W-1:0] seven_bit_port_oe, // seven-bit enables
   input wire logic [INP_W-1:0] input_only_port_i, // pins fourteen, fifteen
   output logic [SEVEN_W-1:0] fast_ext_irq, // fast irq one..seven, bit 0=one
   output logic timer_four_updown_in, // timer four up/down control
   output logic timer_five_updown_in // timer five up/down control
);
   typedef struct packed {
      logic [FOUR_W-1:0] four_dat;
      logic [FOUR_W-1:0] four_dir;
      logic [FOUR_W-1:0] four_od;
      logic [FOUR_W-1:0] four_alt;
      logic [FOUR_W-1:0] four_smp;
      logic [SEVEN_W-1:0] seven_dat;
      logic [SEVEN_W-1:0] seven_dir;
      logic [SEVEN_W-1:0] seven_od;
      logic [SEVEN_W-1:0] seven_smp;
      logic [INP_W-1:0] inp_smp;
      logic [SEVEN_W-1:0] irq_sts;
      logic [SEVEN_W-1:0] irq_msk;
      logic [SEVEN_W-1:0] ext_irq;
      logic tmr4;
      logic tmr5;
      logic irq;
      logic [DATA_W-1:0] rdata;
   } tpio_state_s;

   localparam tpio_state_s ST_RST = '{
      four_dat: FOUR_RST, four_dir: FOUR_RST, four_od: FOUR_RST,
      four_alt: FOUR_RST, four_smp: FOUR_RST,
      seven_dat: SEVEN_RST, seven_dir: SEVEN_RST, seven_od: SEVEN_RST,
      seven_smp: SEVEN_RST, inp_smp: INP_RST,
      irq_sts: SEVEN_RST, irq_msk: SEVEN_RST, ext_irq: SEVEN_RST,
      tmr4: 1'b0, tmr5: 1'b0, irq: 1'b0, rdata: DATA_RST};

   tpio_state_s st_r;
   tpio_state_s st_nxt;

   logic [FOUR_W-1:0] four_val;

   // true when a strobe addresses the given register
   function automatic logic hit(input logic stb,
                                input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] off);
      hit = stb && (a == off);
   endfunction

   // place a seven-bit field at the pin positions of a word
   function automatic logic [DATA_W-1:0] seven_word(
      input logic [SEVEN_W-1:0] f);
      seven_word = DATA_RST;
      seven_word[SEVEN_LSB +: SEVEN_W] = f;
   endfunction

   // place a four-bit field at the low bits of a word
   function automatic logic [DATA_W-1:0] four_word(
      input logic [FOUR_W-1:0] f);
      four_word = DATA_RST;
      four_word[FOUR_LSB +: FOUR_W] = f;
   endfunction

   // next-state logic: registers, sampling, events, read mux
   always_comb begin
      logic [SEVEN_W-1:0] fall;
      logic [SEVEN_W-1:0] clr;
      fall = SEVEN_RST;
      clr = SEVEN_RST;
      st_nxt = st_r;

      // pin sampling for the pin-level register reads
      st_nxt.four_smp = four_bit_port_i;
      st_nxt.seven_smp = seven_bit_port_i;
      st_nxt.inp_smp = input_only_port_i;

      // fast interrupt inputs follow the pin only while it is an input
      st_nxt.ext_irq = seven_bit_port_i & ~st_r.seven_dir;

      // timer up/down controls from the input-only port
      st_nxt.tmr4 = input_only_port_i[0];
      st_nxt.tmr5 = input_only_port_i[1];

      // falling edge on an input pin is a fast interrupt event
      fall = st_r.ext_irq & ~st_nxt.ext_irq;

      // register writes
      if (hit(wr, addr, OFF_FOUR_DAT)) begin
         st_nxt.four_dat = wdata[FOUR_LSB +: FOUR_W];
      end
      if (hit(wr, addr, OFF_FOUR_DIR)) begin
         st_nxt.four_dir = wdata[FOUR_LSB +: FOUR_W];
      end
      if (hit(wr, addr, OFF_FOUR_OD)) begin
         st_nxt.four_od = wdata[FOUR_LSB +: FOUR_W];
      end
      if (hit(wr, addr, OFF_FOUR_ALT)) begin
         st_nxt.four_alt = wdata[FOUR_LSB +: FOUR_W];
      end
      if (hit(wr, addr, OFF_SEVEN_DAT)) begin
         st_nxt.seven_dat = wdata[SEVEN_LSB +: SEVEN_W];
      end
      if (hit(wr, addr, OFF_SEVEN_DIR)) begin
         st_nxt.seven_dir = wdata[SEVEN_LSB +: SEVEN_W];
      end
      if (hit(wr, addr, OFF_SEVEN_OD)) begin
         st_nxt.seven_od = wdata[SEVEN_LSB +: SEVEN_W];
      end
      if (hit(wr, addr, OFF_IRQ_MSK)) begin
         st_nxt.irq_msk = wdata[IRQ_LSB +: SEVEN_W];
      end
      if (hit(wr, addr, OFF_IRQ_STS)) begin
         clr = wdata[IRQ_LSB +: SEVEN_W];
      end

      // sticky status: write one clears, a new event wins over the clear
      st_nxt.irq_sts = (st_r.irq_sts & ~clr) | fall;
      st_nxt.irq = |(st_nxt.irq_sts & st_nxt.irq_msk);

      // read data, valid only in the cycle after the strobe
      st_nxt.rdata = DATA_RST;
      if (rd) begin
         unique case (addr)
            OFF_FOUR_DAT: st_nxt.rdata = four_word(st_r.four_dat);
            OFF_FOUR_DIR: st_nxt.rdata = four_word(st_r.four_dir);
            OFF_FOUR_OD: st_nxt.rdata = four_word(st_r.four_od);
            OFF_FOUR_ALT: st_nxt.rdata = four_word(st_r.four_alt);
            OFF_FOUR_PIN: st_nxt.rdata = four_word(st_r.four_smp);
            OFF_SEVEN_DAT: st_nxt.rdata = seven_word(st_r.seven_dat);
            OFF_SEVEN_DIR: st_nxt.rdata = seven_word(st_r.seven_dir);
            OFF_SEVEN_OD: st_nxt.rdata = seven_word(st_r.seven_od);
            OFF_SEVEN_PIN: st_nxt.rdata = seven_word(st_r.seven_smp);
            OFF_INP_PIN: begin
               st_nxt.rdata[INP_LSB +: INP_W] = st_r.inp_smp;
            end
            OFF_IRQ_STS: begin
               st_nxt.rdata[IRQ_LSB +: SEVEN_W] = st_r.irq_sts;
            end
            OFF_IRQ_MSK: begin
               st_nxt.rdata[IRQ_LSB +: SEVEN_W] = st_r.irq_msk;
            end
            default: st_nxt.rdata = DATA_RST; // unmapped reads zero
         endcase
      end
   end

   // state register
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // chip select replaces the latch on pins with the alternate on
   assign four_val = (st_r.four_alt & chip_select_in) |
                     (~st_r.four_alt & st_r.four_dat);

   // four-bit port pin cells
   genvar gi;
   generate
      for (gi = 0; gi < FOUR_W; gi++) begin : g_four
         tpio_pin_cell u_cell (
            .clk(clk),
            .rst_b(rst_b),
            .dir(st_r.four_dir[gi]),
            .od(st_r.four_od[gi]),
            .val(four_val[gi]),
            .pin_o(four_bit_port_o[gi]),
            .pin_oe(four_bit_port_oe[gi])
         );
      end
      // seven-bit port pin cells
      for (gi = 0; gi < SEVEN_W; gi++) begin : g_seven
         tpio_pin_cell u_cell (
            .clk(clk),
            .rst_b(rst_b),
            .dir(st_r.seven_dir[gi]),
            .od(st_r.seven_od[gi]),
            .val(st_r.seven_dat[gi]),
            .pin_o(seven_bit_port_o[gi]),
            .pin_oe(seven_bit_port_oe[gi])
         );
      end
   endgenerate

   // registered outputs
   assign rdata = st_r.rdata;
   assign irq = st_r.irq;
   assign fast_ext_irq = st_r.ext_irq;
   assign timer_four_updown_in = st_r.tmr4;
   assign timer_five_updown_in = st_r.tmr5;
endmodule
